// [common/spr_pkg.sv]
`default_nettype none
package spr_pkg;
  localparam int LANES    = 4;
  localparam int SLOTS    = 7;
  localparam int WORD_W   = LANES * SLOTS;
  localparam int RGB_W    = 24;
  localparam int CNT_W    = 8;
  localparam int SLOT_W   = 3;
  localparam int FLAT_W   = 5;

  // Output line positions inside the 28-bit assembled word
  localparam int POS_LINE  = 24;
  localparam int POS_FRAME = 25;
  localparam int POS_VALID = 26;
  localparam int POS_SPARE = 27;

  // Timing, in the documented units and as clock counts
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLK_PER_MS    = 1000000 / CLK_PERIOD_NS;
  localparam int LOCK_TIME_MS  = 10;
  localparam int LOCK_CYCLES   = LOCK_TIME_MS * CLK_PER_MS;
  localparam int PD_DELAY_NS   = 1000;
  localparam int PD_DELAY_CYC  = PD_DELAY_NS / CLK_PERIOD_NS;

  localparam logic [CNT_W-1:0]  CNT_MAX   = 8'hff;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 8'h00;
  localparam logic [SLOT_W-1:0] SLOT_DONE = 3'h7;
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 3'h0;

  // Flat bit index (lane * SLOTS + slot) feeding each output line
  localparam logic [FLAT_W-1:0] MAP [0:WORD_W-1] = '{
    5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h19, 5'h1a,
    5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h17, 5'h18,
    5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h15, 5'h16,
    5'h12, 5'h13, 5'h14, 5'h1b
  };

  typedef enum logic [1:0] {
    SPR_SEARCH  = 2'h0,
    SPR_ACQUIRE = 2'h1,
    SPR_LOCKED  = 2'h3
  } spr_lock_e;
endpackage
`default_nettype wire

// [src/spr_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module spr_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Asynchronous in, synchronous out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // spr_sync
`default_nettype wire

// [src/spr_receiver.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Seven bit slots are sampled on every data lane in each link clock period; at under two samples per slot, a period shorter than the last misses slot 6.
// - Slot 0 is sampled first and slot 6 last, spaced one seventh of a period.
// - Outputs carry 8 red, 8 green, 8 blue, line sync, frame sync and valid.
// - Outputs change while the pixel clock rises so its falling edge captures.
// - With power_down_n low every data and control output is held low.
// - Outputs go low within one microsecond of power-down.
// - Data is only presented after a 10 ms lock interval on the link clock.
module spr_receiver
  import spr_pkg::*;
#(
  parameter int LOCK_CYC = spr_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  // Serial link
  input  wire logic [spr_pkg::LANES-1:0] serial_lane_in,
  input  wire logic                      forwarded_clock_in,
  input  wire logic                      power_down_n,
  // Panel side
  output var  logic [spr_pkg::RGB_W-1:0] parallel_word_out,
  output var  logic                      line_sync_out,
  output var  logic                      frame_sync_out,
  output var  logic                      pixel_valid_out,
  output var  logic                      control_spare_out,
  output var  logic                      pixel_clock_out,
  output var  logic                      link_locked_out
);
  import spr_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYC + 1);
  localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYC - 1);

  logic [LANES-1:0]  lane_s;
  logic              link_clk_s;
  logic              pd_n_s;
  logic              link_clk_q;
  logic              rise;
  logic              stall;
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  phase;
  logic [CNT_W-1:0]  period_q;
  logic [SLOT_W-1:0] slot_q;
  logic [SLOT_W-1:0] eff_slot;
  logic [15:0]       target;
  logic              hit;
  logic              word_done;
  logic [WORD_W-1:0] bits_q;
  logic [WORD_W-1:0] mapped;
  logic [LOCK_W-1:0] lock_cnt_q;
  spr_lock_e         lock_q;

  // Lanes, link clock and power-down all enter through two flops
  spr_sync #(
    .W (LANES + 2)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({power_down_n, forwarded_clock_in, serial_lane_in}),
    .q     ({pd_n_s, link_clk_s, lane_s})
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link_clk_q <= 1'b0;
    end else begin
      link_clk_q <= link_clk_s;
    end
  end

  assign rise  = link_clk_s && !link_clk_q;
  // Saturated counter doubles as stall detector, so a link clock
  // slower than CNT_MAX cycles a period reads as stopped
  assign stall = (cnt_q == CNT_MAX);

  // Phase is zero in the cycle of the link clock rise
  always_comb begin
    if (rise) begin
      phase = CNT_ZERO;
    end else if (stall) begin
      phase = CNT_MAX;
    end else begin
      phase = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_q <= CNT_MAX;
    end else begin
      cnt_q <= phase;
    end
  end

  // Period in clock cycles, measured rise to rise
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      period_q <= CNT_ZERO;
    end else if (rise && !stall) begin
      period_q <= cnt_q + 1'b1;
    end
  end

  // Slot k is taken mid-slot at (2k+1)/14 of the period
  assign eff_slot = rise ? SLOT_ZERO : slot_q;
  assign target   = 16'(((32'(eff_slot) * 2 + 1) * 32'(period_q))
                        / (2 * SLOTS));
  assign hit      = (eff_slot != SLOT_DONE) && (16'(phase) == target);
  // Limitation: under two samples per bit slot, so a period shorter than
  // the one measured before it misses slot 6 and gives no word
  // A word counts only if all seven slots fell in the last period
  assign word_done = rise && (slot_q == SLOT_DONE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slot_q <= SLOT_DONE;
    end else if (hit) begin
      slot_q <= eff_slot + 1'b1;
    end else begin
      slot_q <= eff_slot;
    end
  end

  // Deserialise: lane l, slot k lands at flat index l*7+k
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bits_q <= '0;
    end else if (hit) begin
      for (int l = 0; l < LANES; l++) begin
        bits_q[FLAT_W'(l * SLOTS) + FLAT_W'(eff_slot)] <= lane_s[l];
      end
    end
  end

  // Fixed lane-to-line routing
  always_comb begin
    mapped = '0;
    for (int j = 0; j < WORD_W; j++) begin
      mapped[j] = bits_q[MAP[j]];
    end
  end

  // Lock tracking; a stalled link clock or power-down forces relock
  // No frequency check: lock is a fixed count after the first rise
  always_ff @(posedge clock) begin
    if (!rst_n || !pd_n_s) begin
      lock_q     <= SPR_SEARCH;
      lock_cnt_q <= '0;
    end else begin
      unique case (lock_q)
        SPR_SEARCH: begin
          lock_cnt_q <= '0;
          if (rise) begin
            lock_q <= SPR_ACQUIRE;
          end
        end
        SPR_ACQUIRE: begin
          if (stall) begin
            lock_q <= SPR_SEARCH;
          end else if (lock_cnt_q == LOCK_LAST) begin
            lock_q <= SPR_LOCKED;
          end else begin
            lock_cnt_q <= lock_cnt_q + 1'b1;
          end
        end
        SPR_LOCKED: begin
          if (stall) begin
            lock_q <= SPR_SEARCH;
          end
        end
        default: begin
          lock_q <= SPR_SEARCH;
        end
      endcase
    end
  end

  // Power-down clears outputs three cycles after the pin, far inside
  // PD_DELAY_CYC
  always_ff @(posedge clock) begin
    if (!rst_n || !pd_n_s || lock_q != SPR_LOCKED) begin
      parallel_word_out <= '0;
      line_sync_out     <= 1'b0;
      frame_sync_out    <= 1'b0;
      pixel_valid_out   <= 1'b0;
      control_spare_out <= 1'b0;
    end else if (word_done) begin
      // Same cycle as the pixel clock rise
      parallel_word_out <= mapped[RGB_W-1:0];
      line_sync_out     <= mapped[POS_LINE];
      frame_sync_out    <= mapped[POS_FRAME];
      pixel_valid_out   <= mapped[POS_VALID];
      control_spare_out <= mapped[POS_SPARE];
    end
  end

  // Pixel clock high for the first half period, falls mid-word
  // Cleared on stall too, so a stopped link never leaves it high
  always_ff @(posedge clock) begin
    if (!rst_n || !pd_n_s || lock_q != SPR_LOCKED) begin
      pixel_clock_out <= 1'b0;
    end else if (word_done) begin
      pixel_clock_out <= 1'b1;
    end else if (phase == (period_q >> 1) || stall) begin
      pixel_clock_out <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !pd_n_s) begin
      link_locked_out <= 1'b0;
    end else begin
      link_locked_out <= (lock_q == SPR_LOCKED);
    end
  end
endmodule // spr_receiver
`default_nettype wire

// [tb/spr_checker.sv]
`timescale 1ns/100ps
`default_nettype none
module spr_checker #(
  parameter int LOCK_CYC = 50
) (
  // Clock and reset
  input wire logic                      clock,
  input wire logic                      rst_n,
  // Link side
  input wire logic                      forwarded_clock_in,
  input wire logic                      power_down_n,
  // Panel side
  input wire logic [spr_pkg::RGB_W-1:0] parallel_word_out,
  input wire logic                      line_sync_out,
  input wire logic                      frame_sync_out,
  input wire logic                      pixel_valid_out,
  input wire logic                      control_spare_out,
  input wire logic                      pixel_clock_out,
  input wire logic                      link_locked_out
);
  import spr_pkg::*;
  logic        busy;
  logic        fc_q;
  logic [15:0] low_q;
  logic [9:0]  still_q;
  assign busy = |{parallel_word_out, line_sync_out, frame_sync_out,
                  pixel_valid_out, control_spare_out, pixel_clock_out};
  // Counts from the last level change, so it trails the stall detector
  always_ff @(posedge clock) begin
    fc_q <= forwarded_clock_in;
    if (!rst_n || fc_q != forwarded_clock_in) still_q <= '0;
    else if (!still_q[9]) still_q <= still_q + 1'b1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || link_locked_out) low_q <= '0;
    else if (!low_q[15]) low_q <= low_q + 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_clear_a: assert property (disable iff (1'b0)
    !rst_n |=> !busy && !link_locked_out) else $error("busy after reset");
  pd_low_a: assert property (
    !power_down_n [*4] |-> !busy && !link_locked_out) else $error("pd busy");
  pd_bound_a: assert property (
    $fell(power_down_n) |-> ##[1:100] !busy) else $error("pd too slow");
  lock_gap_a: assert property (
    !link_locked_out [*2] |-> !busy) else $error("data while unlocked");
  lock_time_a: assert property (
    $rose(link_locked_out) |-> low_q >= LOCK_CYC) else $error("early lock");
  word_hold_a: assert property (
    $changed(parallel_word_out) && $past(link_locked_out) && link_locked_out
    && power_down_n |-> $rose(pixel_clock_out)) else $error("word moved");
  clk_high_a: assert property (
    $rose(pixel_clock_out) |-> pixel_clock_out [*6] ##1 !pixel_clock_out)
    else $error("strobe timing");
  stall_drop_a: assert property (
    still_q >= 10'h100 |-> !link_locked_out)
    else $error("lock kept on stall");
  cover property ($rose(link_locked_out));
  cover property ($fell(power_down_n));
  cover property ($fell(link_locked_out) && power_down_n);
endmodule // spr_checker
bind spr_receiver spr_checker #(.LOCK_CYC(LOCK_CYC)) u_chk (.clock, .rst_n,
  .forwarded_clock_in, .power_down_n, .parallel_word_out, .line_sync_out,
  .frame_sync_out, .pixel_valid_out, .control_spare_out, .pixel_clock_out,
  .link_locked_out);
`default_nettype wire

// [tb/spr_tx_model.sv]
`timescale 1ns/100ps
`default_nettype none
module spr_tx_model (
  // Bench control
  input  wire logic                       run,
  input  wire logic [spr_pkg::WORD_W-1:0] word,
  // Link pins
  output var  logic [spr_pkg::LANES-1:0]  serial_lane_in,
  output var  logic                       forwarded_clock_in
);
  import spr_pkg::*;
  logic [WORD_W-1:0] w;
  initial begin
    serial_lane_in = '0;
    forwarded_clock_in = 1'b0;
    forever begin
      wait (run);
      w = word;
      for (int s = 0; s < SLOTS; s++) begin
        forwarded_clock_in = s < 4;
        for (int l = 0; l < LANES; l++)
          serial_lane_in[l] = w[l*SLOTS+s];
        // 100 ps grid cannot split 125 ns evenly
        #(s < 6 ? 17.8 : 18.2);
      end
      // Stopped lanes never hold their last value
      if (!run) serial_lane_in = ~serial_lane_in;
    end
  end
endmodule // spr_tx_model
`default_nettype wire

// [tb/spr_receiver_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module spr_receiver_tb;
  import spr_pkg::*;
  `define CHECK(g, e, m) begin checked++; if ((g) !== (e)) begin \
    num_errors++; $display("CHECK FAILED at %0t: %s", $time, m); end end
  logic              clock = 1'b0;
  logic              rst_n = 1'b0;
  logic              power_down_n = 1'b1;
  logic              run = 1'b0;
  logic [WORD_W-1:0] word = 28'h5a3c96e;
  logic [LANES-1:0]  serial_lane_in;
  logic              forwarded_clock_in;
  logic [RGB_W-1:0]  parallel_word_out;
  logic              line_sync_out, frame_sync_out, pixel_valid_out;
  logic              control_spare_out, pixel_clock_out, link_locked_out;
  logic [WORD_W-1:0] got;
  int                num_errors = 0;
  int                checked = 0;
  assign got = {control_spare_out, pixel_valid_out, frame_sync_out,
                line_sync_out, parallel_word_out};
  always #5 clock = ~clock;
  spr_tx_model u_tx (.run, .word, .serial_lane_in, .forwarded_clock_in);
  spr_receiver #(.LOCK_CYC(50)) dut (.clock, .rst_n, .serial_lane_in,
    .forwarded_clock_in, .power_down_n, .parallel_word_out, .line_sync_out,
    .frame_sync_out, .pixel_valid_out, .control_spare_out, .pixel_clock_out,
    .link_locked_out);
  function automatic logic [WORD_W-1:0] mapped(logic [WORD_W-1:0] w);
    for (int j = 0; j < WORD_W; j++) mapped[j] = w[MAP[j]];
  endfunction
  task automatic cycles(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check_word(string m);
    `CHECK({link_locked_out, got}, {1'b1, mapped(word)}, m)
  endtask
  task automatic check_quiet(string m);
    `CHECK({link_locked_out, pixel_clock_out, got}, 30'h0, m)
  endtask
  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic lock_up();
    run = 1'b1;
    cycles(20);
    check_quiet("output before lock");
    cycles(150);
    check_word("first word");
  endtask
  task automatic back_to_back();
    word = ~word;
    cycles(50);
    check_word("second word");
    word = 28'h8000001;
    cycles(50);
    check_word("edge bits");
    // Lane 0 slot 0 is word bit 16, lane 3 slot 6 the spare line
    `CHECK(got, 28'h8010000, "edge bit lines")
  endtask
  task automatic power_down();
    // Strike in the low half so the strobe is never cut short
    @(negedge pixel_clock_out);
    cycles(1);
    power_down_n = 1'b0;
    cycles(4);
    check_quiet("power-down");
    cycles(60);
    check_quiet("power-down hold");
    power_down_n = 1'b1;
    cycles(30);
    check_quiet("relock early");
    cycles(150);
    check_word("after power-up");
  endtask
  task automatic stall();
    run = 1'b0;
    cycles(300);
    check_quiet("stalled link");
    run = 1'b1;
    cycles(170);
    check_word("after stall");
  endtask
  initial begin
    // Whole run needs about 1000 cycles
    #50000;
    num_errors++;
    results();
  end
  initial begin
    cycles(3);
    rst_n = 1'b1;
    lock_up();
    back_to_back();
    power_down();
    stall();
    results();
  end
endmodule // spr_receiver_tb
`default_nettype wire
